// ===== inc/dac_defs.svh
// Constants for the serial converter front end
`ifndef DAC_DEFS_SVH
`define DAC_DEFS_SVH
`define WORD_BITS 16
`define MIDSCALE_CODE 16'h0000
`define POS_FULL_CODE 16'h7fff
`define NEG_FULL_CODE 16'h8000
`endif

// ===== inc/dac_pkg.sv
// Types shared by the converter front end
package dac_pkg;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_SHIFT = 2'b01,
    MODE_LOAD = 2'b10,
    MODE_BOTH = 2'b11
  } stage_mode_type;
endpackage

// ===== sim/host_model.sv
// Host side driving serial clock, data and enables
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic serial_clock,
  output logic serial_data_in,
  output logic in_en_n,
  output logic out_en_n
);
  initial begin
    serial_clock = 1'b1;
    serial_data_in = 1'b0;
    in_en_n = 1'b1;
    out_en_n = 1'b1;
  end
  // One high-low-high serial cycle
  task automatic cycle(input logic a, input logic l, input logic b);
    @(negedge clk);
    serial_clock = 1'b0;
    in_en_n = a;
    out_en_n = l;
    serial_data_in = b;
    repeat (2) @(negedge clk);
    serial_clock = 1'b1;
    repeat (2) @(negedge clk);
    serial_data_in = ~b;
    in_en_n = 1'b1;
    out_en_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== sim/serial_dac_double_buffer_test.sv
// Self-checking bench for the converter front end
`timescale 1ns/1ps
`default_nettype none
`include "dac_defs.svh"
module serial_dac_double_buffer_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clear_n = 1'b1;
  logic sck, data_in, in_en_n, out_en_n, data_out, zero_flag;
  logic [15:0] code, sr, w;
  logic [15:0] corner [3] = '{`POS_FULL_CODE, `NEG_FULL_CODE, 16'h0000};
  logic [31:0] rnd = 32'h0c325845;
  int n_errors = 0;
  int cmp_count = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  host_model i_host_model (.clk(clk), .serial_clock(sck),
    .serial_data_in(data_in), .in_en_n(in_en_n), .out_en_n(out_en_n));
  serial_dac_double_buffer i_serial_dac_double_buffer (.clk(clk),
    .resetn(resetn), .serial_clock(sck), .serial_data_in(data_in),
    .input_stage_enable_n(in_en_n), .output_latch_enable_n(out_en_n),
    .clear_n(clear_n), .serial_data_out(data_out),
    .twos_complement_code(code), .at_bipolar_zero(zero_flag));
  // Pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected input stage after one bit, MSB first
  function automatic logic [15:0] shifted(logic [15:0] s, logic b);
    return {s[14:0], b};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One serial cycle plus the expected shift stage
  task automatic bit_in(logic a, logic l, logic b);
    i_host_model.cycle(a, l, b);
    if (!a) sr = shifted(sr, b);
  endtask
  task automatic send(logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      bit_in(1'b0, 1'b1, v[i]);
      chk("data_out", {15'h0, sr[15]}, {15'h0, data_out});
      chk("held", w, code);
    end
  endtask
  task automatic load();
    bit_in(1'b1, 1'b0, 1'b0);
    w = sr;
    chk("code", w, code);
    chk("zero_flag", {15'h0, w == 16'h0}, {15'h0, zero_flag});
    chk("load_out", {15'h0, sr[15]}, {15'h0, data_out});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    w = 16'h0;
    sr = 16'h0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    chk("rst", 16'h0, code);
    chk("rst_out", 16'h0, {15'h0, data_out});
    chk("rst_flag", 16'h1, {15'h0, zero_flag});
    for (int k = 0; k < 7; k++) begin
      rnd = lfsr(rnd);
      send(k < 3 ? corner[k] : rnd[15:0]);
      load();
    end
    $display("test words done");
    bit_in(1'b1, 1'b1, 1'b1);
    chk("none", w, code);
    chk("none_out", {15'h0, sr[15]}, {15'h0, data_out});
    bit_in(1'b0, 1'b0, 1'b1);
    w = sr;
    chk("flow", w, code);
    chk("flow_out", {15'h0, sr[15]}, {15'h0, data_out});
    $display("test modes done");
    clear_n = 1'b0;
    @(negedge clk);
    chk("clear", 16'h0, code);
    chk("clear_out", 16'h0, {15'h0, data_out});
    chk("clear_flag", 16'h1, {15'h0, zero_flag});
    bit_in(1'b0, 1'b0, 1'b1);
    chk("clear_wins", 16'h0, code);
    chk("clear_wins_out", 16'h0, {15'h0, data_out});
    clear_n = 1'b1;
    sr = 16'h0;
    bit_in(1'b0, 1'b1, 1'b1);
    load();
    $display("test clear done");
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #50us;
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== src/sclk_edge.sv
// Rising edge detector for the host serial clock
`timescale 1ns/1ps
`default_nettype none
module sclk_edge (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level_in,
  output logic rise
);
  logic prev_reg;
  logic prev_next;

  // Next value of the held level
  always_comb begin
    prev_next = level_in;
  end

  // Idle level of the serial clock is high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // High after low completes a clock cycle
  assign rise = level_in & ~prev_reg;

  // A rise lasts one clock, so one serial cycle acts once
  rise_single_a: assert property (
    @(posedge clk) disable iff (!resetn) rise |=> !rise)
    else $error("serial clock rise seen twice");
endmodule
`default_nettype wire

// ===== src/serial_dac_double_buffer.sv
// Double buffered serial front end of a 16-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "dac_defs.svh"

module serial_dac_double_buffer
  import dac_pkg::*;
#(
  parameter int WIDTH = `WORD_BITS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic input_stage_enable_n,
  input wire logic output_latch_enable_n,
  input wire logic clear_n,
  output logic serial_data_out,
  output logic [WIDTH-1:0] twos_complement_code,
  output logic at_bipolar_zero
);
  // Input stage and output latch with their next values
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] shift_next;
  logic [WIDTH-1:0] latch_reg;
  logic [WIDTH-1:0] latch_next;

  // Registered status outputs
  logic out_bit_reg;
  logic out_bit_next;
  logic zero_flag_reg;
  logic zero_flag_next;

  // Decoded serial clock edge and enable mode
  logic sclk_rise;
  stage_mode_type mode;

  // Serial clock edge from a single-cycle detector
  sclk_edge u_edge (
    .clk(clk),
    .resetn(resetn),
    .level_in(serial_clock),
    .rise(sclk_rise)
  );

  // Active low enables form the mode
  assign mode = stage_mode_type'({~output_latch_enable_n,
                                  ~input_stage_enable_n});

  // Next state of the two stages
  // Clear is sampled like every pin, so it acts one clock late
  // but wins every edge on which it is low, rise or not
  always_comb begin
    shift_next = shift_reg;
    latch_next = latch_reg;
    if (!clear_n) begin
      shift_next = WIDTH'(`MIDSCALE_CODE);
      latch_next = WIDTH'(`MIDSCALE_CODE);
    end else if (sclk_rise) begin
      case (mode)
        MODE_SHIFT: begin
          // MSB first: new bit enters at the bottom
          shift_next = {shift_reg[WIDTH-2:0], serial_data_in};
        end
        MODE_LOAD: begin
          latch_next = shift_reg;
        end
        MODE_BOTH: begin
          // Data flows through both stages in one edge
          shift_next = {shift_reg[WIDTH-2:0], serial_data_in};
          latch_next = {shift_reg[WIDTH-2:0], serial_data_in};
        end
        MODE_IDLE: begin
          // Both disabled: hold
          shift_next = shift_reg;
          latch_next = latch_reg;
        end
        default: begin
          // Unreachable code: hold as well
          shift_next = shift_reg;
          latch_next = latch_reg;
        end
      endcase
    end
  end

  // Registering of the two stages
  always_ff @(posedge clk) begin
    if (!resetn) begin
      shift_reg <= WIDTH'(`MIDSCALE_CODE);
      latch_reg <= WIDTH'(`MIDSCALE_CODE);
    end else begin
      shift_reg <= shift_next;
      latch_reg <= latch_next;
    end
  end

  // Status outputs follow the stages on the same edge
  always_comb begin
    out_bit_next = shift_next[WIDTH-1];
    zero_flag_next = (latch_next == WIDTH'(`MIDSCALE_CODE));
  end

  // Registering of the status outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_bit_reg <= 1'b0;
      zero_flag_reg <= 1'b1;
    end else begin
      out_bit_reg <= out_bit_next;
      zero_flag_reg <= zero_flag_next;
    end
  end

  // Latch code goes to the core as is
  assign twos_complement_code = latch_reg;
  assign serial_data_out = out_bit_reg;
  assign at_bipolar_zero = zero_flag_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  clear_forces_zero_a: assert property (
    !clear_n |=> shift_reg == '0 && latch_reg == '0)
    else $error("clear did not zero both stages");
  shift_bit_in_a: assert property (
    clear_n && sclk_rise && mode == MODE_SHIFT |=>
    shift_reg[0] == $past(serial_data_in) &&
    latch_reg == $past(latch_reg))
    else $error("shift did not take data bit");
  load_copies_a: assert property (
    clear_n && sclk_rise && mode == MODE_LOAD |=>
    latch_reg == $past(shift_reg) && shift_reg == $past(shift_reg))
    else $error("load did not copy input stage");
  hold_when_idle_a: assert property (
    clear_n && !(sclk_rise && mode != MODE_IDLE) |=>
    $stable(shift_reg) && $stable(latch_reg))
    else $error("stage changed while disabled");
  latch_needs_load_a: assert property (
    clear_n && mode == MODE_SHIFT |=> $stable(latch_reg))
    else $error("latch moved during shift");
  out_bit_msb_a: assert property (
    serial_data_out == shift_reg[WIDTH-1])
    else $error("serial output not last bit");
  flow_through_a: assert property (
    clear_n && sclk_rise && mode == MODE_BOTH |=>
    latch_reg == shift_reg)
    else $error("both enabled did not flow through");
  zero_flag_a: assert property (
    at_bipolar_zero == (twos_complement_code == `MIDSCALE_CODE))
    else $error("bipolar zero flag wrong");
  word_msb_first_a: assert property (
    clear_n && sclk_rise && mode == MODE_SHIFT |=>
    shift_reg[WIDTH-1:1] == $past(shift_reg[WIDTH-2:0]))
    else $error("word not assembled msb first");

  // Reset and clear outcomes
  after_reset_a: assert property (
    $rose(resetn) |->
    twos_complement_code == '0 && !serial_data_out && at_bipolar_zero)
    else $error("outputs not at midscale after reset");
  clear_output_state_a: assert property (
    !clear_n |=> !serial_data_out && at_bipolar_zero)
    else $error("clear left serial output or flag wrong");
  clear_wins_a: assert property (
    !clear_n && sclk_rise && mode != MODE_IDLE |=>
    shift_reg == '0 && latch_reg == '0)
    else $error("clocked action beat clear");

  // Per mode effects of one serial clock rise, and hold when there is no rise
  idle_no_change_a: assert property (
    clear_n && sclk_rise && mode == MODE_IDLE |=>
    $stable(shift_reg) && $stable(latch_reg))
    else $error("stages changed with both enables high");
  no_rise_hold_a: assert property (
    clear_n && !sclk_rise |=>
    $stable(shift_reg) && $stable(latch_reg))
    else $error("stages moved without a serial clock rise");
  flow_shift_a: assert property (
    clear_n && sclk_rise && mode == MODE_BOTH |=>
    shift_reg == {$past(shift_reg[WIDTH-2:0]), $past(serial_data_in)})
    else $error("both enabled did not shift");
  load_keeps_bit_a: assert property (
    clear_n && sclk_rise && mode == MODE_LOAD |=> $stable(serial_data_out))
    else $error("serial output moved on load");
  shift_next_bit_a: assert property (
    clear_n && sclk_rise && mode == MODE_SHIFT |=>
    serial_data_out == $past(shift_reg[WIDTH-2]))
    else $error("serial output not the bit shifted out");
  flow_next_bit_a: assert property (
    clear_n && sclk_rise && mode == MODE_BOTH |=>
    serial_data_out == $past(shift_reg[WIDTH-2]))
    else $error("serial output wrong in flow through");
  zero_on_load_a: assert property (
    clear_n && sclk_rise && mode == MODE_LOAD |=>
    at_bipolar_zero == ($past(shift_reg) == '0))
    else $error("zero flag wrong after load");

  // Cover points for the main scenarios
  shift_seen_c: cover property (sclk_rise && mode == MODE_SHIFT);
  load_seen_c: cover property (sclk_rise && mode == MODE_LOAD);
  clear_seen_c: cover property (!clear_n ##1 clear_n);
  posfull_c: cover property (twos_complement_code == `POS_FULL_CODE);
  negfull_c: cover property (twos_complement_code == `NEG_FULL_CODE);
endmodule
`default_nettype wire
